// File: rtl/gpip_pkg.sv
// Package with register map, field masks and carrier types of the two-port GPIO block.
package gpip_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int AW = 4;
   localparam int DW = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [AW-1:0] OFS_H_PULL_EN = 4'h0;
   localparam logic [AW-1:0] OFS_H_POL = 4'h1;
   localparam logic [AW-1:0] OFS_H_IE = 4'h2;
   localparam logic [AW-1:0] OFS_H_IF = 4'h3;
   localparam logic [AW-1:0] OFS_J_DATA = 4'h4;
   localparam logic [AW-1:0] OFS_J_IN = 4'h5;
   localparam logic [AW-1:0] OFS_J_DIR = 4'h6;
   localparam logic [AW-1:0] OFS_J_RDR = 4'h7;
   localparam logic [AW-1:0] OFS_J_POL = 4'h8;
   localparam logic [AW-1:0] OFS_J_IE = 4'h9;
   localparam logic [AW-1:0] OFS_J_IF = 4'hA;

   // ----------------------------------------------------------------
   // Field masks and reset values
   // ----------------------------------------------------------------
   localparam logic [DW-1:0] H_IMPL_MASK = 8'hFF;
   localparam logic [DW-1:0] J_IMPL_MASK = 8'hC3;
   localparam logic [DW-1:0] REG_RESET = 8'h00;
   localparam logic [DW-1:0] RD_UNMAPPED = 8'h00;
   localparam logic [1:0] RST_SYNC_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [DW-1:0] pull_en;
      logic [DW-1:0] pol;
      logic [DW-1:0] ie;
   } gpip_hcfg_t;

   typedef struct packed {
      logic [DW-1:0] data;
      logic [DW-1:0] dir;
      logic [DW-1:0] rdr;
      logic [DW-1:0] pol;
      logic [DW-1:0] ie;
   } gpip_jcfg_t;

endpackage

// File: rtl/gpip_ports.sv
// Two-port GPIO block: pull control, edge pin interrupts, data and drive control.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Pin synchroniser, edge detector and sticky flags for one port
// ----------------------------------------------------------------
module gpip_edge_flags
   import gpip_pkg::*;
#(
   parameter logic [DW-1:0] MASK = 8'hFF
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [DW-1:0] pin_in,
   input wire logic [DW-1:0] pol,
   input wire logic [DW-1:0] clr,
   output logic [DW-1:0] pin_s,
   output logic [DW-1:0] pin_p,
   output logic [DW-1:0] act,
   output logic [DW-1:0] flags
);
   logic [DW-1:0] meta_q;
   logic [DW-1:0] sync_q;
   logic [DW-1:0] prev_q;
   logic [DW-1:0] flags_q;
   logic [DW-1:0] flags_d;
   logic [DW-1:0] rise;
   logic [DW-1:0] fall;

   // The first stage only feeds the second; edges look at stages two and three.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= REG_RESET;
         sync_q <= REG_RESET;
         prev_q <= REG_RESET;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge choice follows the polarity bit, which on the first port also selects the pull.
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
   assign act = MASK & ((rise & pol) | (fall & ~pol));
   // A new edge in the clearing cycle wins, so no event is lost.
   assign flags_d = MASK & ((flags_q & ~clr) | act);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= REG_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign pin_s = sync_q;
   assign pin_p = prev_q;
   assign flags = flags_q;
endmodule

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module gpip_ports
   import gpip_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DW-1:0] reg_rdata,
   input wire logic [DW-1:0] hport_pin_in,
   input wire logic [DW-1:0] hport_dir,
   output logic [DW-1:0] hport_pull_on,
   output logic [DW-1:0] hport_pull_down,
   output logic hport_irq,
   input wire logic [DW-1:0] jport_pin_in,
   output logic [DW-1:0] jport_pin_out,
   output logic [DW-1:0] jport_pin_oe,
   output logic [DW-1:0] jport_drive_reduced,
   output logic jport_irq
);
   logic [1:0] rst_q;
   logic rst_n;
   gpip_hcfg_t h_q;
   gpip_hcfg_t h_d;
   gpip_jcfg_t j_q;
   gpip_jcfg_t j_d;
   logic [DW-1:0] rdata_q;
   logic [DW-1:0] rdata_d;
   logic [DW-1:0] h_pin_s;
   logic [DW-1:0] h_pin_p;
   logic [DW-1:0] h_act;
   logic [DW-1:0] h_flags;
   logic [DW-1:0] j_pin_s;
   logic [DW-1:0] j_pin_p;
   logic [DW-1:0] j_act;
   logic [DW-1:0] j_flags;
   logic [DW-1:0] wm;
   logic [DW-1:0] h_clr;
   logic [DW-1:0] j_clr;
   logic [DW-1:0] j_data_rd;
   logic [DW-1:0] j_wr_val;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   // Assertion is immediate; release waits two edges so no flop sees a runt.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_q <= RST_SYNC_RESET;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   // The input register offset has no write term, so a write there is dropped.
   assign wm = reg_wr ? reg_wdata : REG_RESET;
   assign j_wr_val = reg_wdata & J_IMPL_MASK;
   assign h_clr = (reg_addr == OFS_H_IF) ? wm : REG_RESET;
   assign j_clr = (reg_addr == OFS_J_IF) ? (wm & J_IMPL_MASK) : REG_RESET;
   assign h_d.pull_en = (reg_wr && reg_addr == OFS_H_PULL_EN) ? reg_wdata : h_q.pull_en;
   assign h_d.pol = (reg_wr && reg_addr == OFS_H_POL) ? reg_wdata : h_q.pol;
   assign h_d.ie = (reg_wr && reg_addr == OFS_H_IE) ? reg_wdata : h_q.ie;
   assign j_d.data = (reg_wr && reg_addr == OFS_J_DATA) ? j_wr_val : j_q.data;
   assign j_d.dir = (reg_wr && reg_addr == OFS_J_DIR) ? j_wr_val : j_q.dir;
   assign j_d.rdr = (reg_wr && reg_addr == OFS_J_RDR) ? j_wr_val : j_q.rdr;
   assign j_d.pol = (reg_wr && reg_addr == OFS_J_POL) ? j_wr_val : j_q.pol;
   assign j_d.ie = (reg_wr && reg_addr == OFS_J_IE) ? j_wr_val : j_q.ie;

   // Control registers; all clear to zero at reset.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         h_q <= '0;
         j_q <= '0;
      end else begin
         h_q <= h_d;
         j_q <= j_d;
      end
   end

   // ----------------------------------------------------------------
   // Edge detection and flags
   // ----------------------------------------------------------------
   gpip_edge_flags #(.MASK(H_IMPL_MASK)) u_hport (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_in(hport_pin_in),
      .pol(h_q.pol),
      .clr(h_clr),
      .pin_s(h_pin_s),
      .pin_p(h_pin_p),
      .act(h_act),
      .flags(h_flags)
   );

   // Edges are watched on the pin itself, so outputs flag as well.
   gpip_edge_flags #(.MASK(J_IMPL_MASK)) u_jport (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_in(jport_pin_in),
      .pol(j_q.pol),
      .clr(j_clr),
      .pin_s(j_pin_s),
      .pin_p(j_pin_p),
      .act(j_act),
      .flags(j_flags)
   );

   // ----------------------------------------------------------------
   // Pin control and interrupt requests
   // ----------------------------------------------------------------
   // A pull makes no sense against a driven pin, so direction gates it.
   assign hport_pull_on = h_q.pull_en & ~hport_dir;
   assign hport_pull_down = h_q.pol;
   assign hport_irq = |(h_flags & h_q.ie);
   assign jport_irq = |(j_flags & j_q.ie);
   assign jport_pin_oe = j_q.dir;
   assign jport_pin_out = j_q.data;
   // Strength only matters while something drives the pin.
   assign jport_drive_reduced = j_q.rdr & j_q.dir;

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Synchronised pin state is used, so reads lag the pin by two cycles.
   assign j_data_rd = J_IMPL_MASK & ((j_q.dir & j_q.data) | (~j_q.dir & j_pin_s));
   assign rdata_d = !reg_rd ? REG_RESET :
                    (reg_addr == OFS_H_PULL_EN) ? h_q.pull_en :
                    (reg_addr == OFS_H_POL) ? h_q.pol :
                    (reg_addr == OFS_H_IE) ? h_q.ie :
                    (reg_addr == OFS_H_IF) ? h_flags :
                    (reg_addr == OFS_J_DATA) ? j_data_rd :
                    (reg_addr == OFS_J_IN) ? (j_pin_s & J_IMPL_MASK) :
                    (reg_addr == OFS_J_DIR) ? j_q.dir :
                    (reg_addr == OFS_J_RDR) ? j_q.rdr :
                    (reg_addr == OFS_J_POL) ? j_q.pol :
                    (reg_addr == OFS_J_IE) ? j_q.ie :
                    (reg_addr == OFS_J_IF) ? j_flags : RD_UNMAPPED;

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= REG_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata = rdata_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_pull_after_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_H_PULL_EN) ##1 $stable(hport_dir)
      |-> hport_pull_on == ($past(reg_wdata) & ~hport_dir))
      else $error("pull enable not applied to input pins");

   a_rise_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ((h_pin_s & ~h_pin_p & h_q.pol) != 8'h00)
      |=> (h_flags & $past(h_pin_s & ~h_pin_p & h_q.pol)) == $past(h_pin_s & ~h_pin_p & h_q.pol))
      else $error("rising edge did not set flag");

   a_fall_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ((~h_pin_s & h_pin_p & ~h_q.pol) != 8'h00)
      |=> (h_flags & $past(~h_pin_s & h_pin_p & ~h_q.pol)) == $past(~h_pin_s & h_pin_p & ~h_q.pol))
      else $error("falling edge did not set flag");

   a_wrong_edge_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ((h_flags & ~$past(h_flags)
        & ~$past((h_pin_s & ~h_pin_p & h_q.pol) | (~h_pin_s & h_pin_p & ~h_q.pol))) == 8'h00))
      else $error("edge of wrong polarity flagged");

   a_w1c_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_H_IF)
      |=> ((h_flags & $past(reg_wdata & ~h_act)) == 8'h00)
          && ((h_flags & ~$past(reg_wdata)) == ($past(h_flags | h_act) & ~$past(reg_wdata))))
      else $error("flag clear by write-one failed");

   a_irq_enabled_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ((h_flags & h_q.ie) != 8'h00) |-> hport_irq)
      else $error("enabled flag raised no request");

   a_irq_needs_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
      hport_irq |-> (h_flags & h_q.ie) != 8'h00)
      else $error("request without enabled flag");

   a_jflag_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (j_act != 8'h00) |=> ((j_flags & $past(j_act)) == $past(j_act)) && ((j_flags & ~J_IMPL_MASK) == 8'h00))
      else $error("second port edge not flagged");

   a_jdata_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFS_J_DATA)
      |=> reg_rdata == $past(J_IMPL_MASK & ((j_q.dir & j_q.data) | (~j_q.dir & j_pin_s))))
      else $error("data register read from wrong source");

   a_jin_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFS_J_IN) |=> reg_rdata == $past(j_pin_s & J_IMPL_MASK))
      else $error("input register not pin state");

   a_jin_write_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_J_IN) |=> $stable(j_q) && $stable(h_q))
      else $error("write to input register changed state");

   a_jdrive_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_J_DIR) |=> jport_pin_oe == ($past(reg_wdata) & J_IMPL_MASK)
      ##0 jport_pin_out == j_q.data)
      else $error("direction write not driven to pins");

   a_reduced_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_J_RDR) ##1 $stable(j_q.dir)
      |-> jport_drive_reduced == ($past(reg_wdata) & J_IMPL_MASK & j_q.dir))
      else $error("reduced drive not gated by direction");

   a_reset_clear: assert property (@(posedge ref_clk) $rose(rst_n)
      |-> h_q == '0 && j_q == '0 && h_flags == 8'h00 && !hport_irq && !jport_irq)
      else $error("state not cleared by reset");

   // Masking and the second port's request line.
   a_irq_off_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (h_q.ie == 8'h00) |-> !hport_irq)
      else $error("masked flags raised a request");

   a_jirq_request: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ((j_flags & j_q.ie) != 8'h00) |-> jport_irq)
      else $error("second port enabled flag raised no request");

   a_jirq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (j_q.ie == 8'h00) |-> !jport_irq)
      else $error("second port masked flags raised a request");

   // Pull control follows the registers and never fights a driven pin.
   a_pull_down_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_H_POL) |=> hport_pull_down == $past(reg_wdata))
      else $error("pull direction does not follow polarity");

   a_pull_out_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (hport_pull_on & hport_dir) == 8'h00)
      else $error("pull device on for a driven pin");

   // Flags are sticky: only a written one removes them, and a new edge beats the clear.
   a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(reg_wr && reg_addr == OFS_H_IF) |=> (h_flags & $past(h_flags)) == $past(h_flags))
      else $error("flag dropped without a clear");

   a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_H_IF) |=> (h_flags & $past(h_act)) == $past(h_act))
      else $error("edge lost in the clearing cycle");

   a_hflags_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFS_H_IF) |=> reg_rdata == $past(h_flags))
      else $error("flag register read wrong");

   a_jflag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(reg_wr && reg_addr == OFS_J_IF) |=> (j_flags & $past(j_flags)) == $past(j_flags))
      else $error("second port flag dropped without a clear");

   a_jflag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_J_IF) |=> (j_flags & $past(reg_wdata & J_IMPL_MASK & ~j_act)) == 8'h00)
      else $error("second port flag not cleared by write-one");

   a_jpol_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ((j_flags & ~$past(j_flags)
        & ~$past((j_pin_s & ~j_pin_p & j_q.pol) | (~j_pin_s & j_pin_p & ~j_q.pol))) == 8'h00))
      else $error("second port flag set without its active edge");

   // Second port pins: missing bits stay quiet and the drive follows the registers.
   a_junimpl_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ((jport_pin_out | jport_pin_oe | jport_drive_reduced | j_flags) & ~J_IMPL_MASK) == 8'h00)
      else $error("unimplemented second port bit active");

   a_jdata_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_J_DATA) |=> jport_pin_out == ($past(reg_wdata) & J_IMPL_MASK))
      else $error("data write not driven to pins");

   a_jreduced_input: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (jport_drive_reduced & ~jport_pin_oe) == 8'h00)
      else $error("reduced drive set on an input pin");

   // Both synchronisers are exactly two stages deep once reset has been gone two cycles.
   a_pin_sync_lag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n, 2) |-> h_pin_s == $past(hport_pin_in, 2) && j_pin_s == $past(jport_pin_in, 2))
      else $error("pin synchroniser depth wrong");

endmodule

`default_nettype wire

// File: tb/gpip_board.sv
// Board model that drives the pins of both ports from outside the block.
`timescale 1ns/100ps
`default_nettype none
module gpip_board
   import gpip_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [DW-1:0] hport_pull_on,
   input wire logic [DW-1:0] hport_pull_down,
   input wire logic [DW-1:0] h_ext_val,
   input wire logic [DW-1:0] h_ext_drv,
   input wire logic [DW-1:0] jport_pin_out,
   input wire logic [DW-1:0] jport_pin_oe,
   input wire logic [DW-1:0] j_ext_val,
   input wire logic [DW-1:0] j_short_mask,
   input wire logic [DW-1:0] j_short_val,
   output logic [DW-1:0] hport_pin_in,
   output logic [DW-1:0] jport_pin_in
);
   logic [DW-1:0] h_last_q;
   // A floating pin flips every cycle, so a stale level never looks like a pull.
   always_ff @(posedge ref_clk) begin
      h_last_q <= hport_pin_in;
   end
   // Driven pins win, then the selected pull device, then the flipping float.
   assign hport_pin_in = (h_ext_drv & h_ext_val) | (~h_ext_drv & hport_pull_on & ~hport_pull_down)
      | (~h_ext_drv & ~hport_pull_on & ~h_last_q);
   // A commanded short overrides the block's driver; otherwise the enable decides.
   assign jport_pin_in = (j_short_mask & j_short_val) | (~j_short_mask & ((jport_pin_oe & jport_pin_out)
      | (~jport_pin_oe & j_ext_val)));
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the two-port GPIO block.
`timescale 1ns/100ps
`default_nettype none
module testbench
   import gpip_pkg::*;
;
   logic ref_clk, nrst, reg_wr, reg_rd, hport_irq, jport_irq;
   logic [AW-1:0] reg_addr;
   logic [DW-1:0] reg_wdata, reg_rdata, hport_dir, hport_pull_on, hport_pull_down;
   logic [DW-1:0] jport_pin_out, jport_pin_oe, jport_drive_reduced, hport_pin_in, jport_pin_in;
   logic [DW-1:0] h_ext_val, h_ext_drv, j_ext_val, j_short_mask, j_short_val;
   logic [7:0] lfsr_q;
   int fails, compares;
   logic [3:0] rw_ofs [7] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9};
   logic [7:0] rw_msk [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hC3, 8'hC3, 8'hC3, 8'hC3};

   gpip_ports dut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .hport_pin_in, .hport_dir, .hport_pull_on, .hport_pull_down, .hport_irq, .jport_pin_in,
      .jport_pin_out, .jport_pin_oe, .jport_drive_reduced, .jport_irq);
   gpip_board board (.ref_clk, .hport_pull_on, .hport_pull_down, .h_ext_val, .h_ext_drv,
      .jport_pin_out, .jport_pin_oe, .j_ext_val, .j_short_mask, .j_short_val,
      .hport_pin_in, .jport_pin_in);

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic rnd(output logic [7:0] v);
      lfsr_q = lfsr_next(lfsr_q);
      v = lfsr_q;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // Three edges carry a pin change to its flag; one spare edge is allowed.
   task automatic settle;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
   task automatic set_pins(input logic [3:0] b, input logic [7:0] v);
      if (b == OFS_H_POL) h_ext_val <= v;
      else j_ext_val <= v;
   endtask
   task automatic irq_case(input logic [3:0] b, input logic [7:0] k, input logic pol);
      logic [7:0] m, ie, f;
      logic irq;
      rnd(m);
      rnd(ie);
      set_pins(b, {8{~pol}});
      wr(b, {8{pol}});
      settle;
      wr(b + 4'h2, 8'hFF);
      wr(b + 4'h1, ie);
      set_pins(b, {8{~pol}} ^ m);
      settle;
      f = m & k;
      rchk(b + 4'h2, f);
      irq = (b == OFS_H_POL) ? hport_irq : jport_irq;
      chk({7'h00, irq}, {7'h00, |(f & ie)});
      wr(b + 4'h2, 8'h0F);
      rchk(b + 4'h2, f & 8'hF0);
      irq = (b == OFS_H_POL) ? hport_irq : jport_irq;
      chk({7'h00, irq}, {7'h00, |(f & ie & 8'hF0)});
   endtask
   task automatic print_verdict;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // The tests need a few hundred cycles; thirty thousand means a hang.
   initial begin
      #3000000;
      fails++;
      $display("watchdog expired");
      print_verdict();
   end
   initial begin
      logic [7:0] d, r, s, x, p;
      {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, hport_dir, j_ext_val, j_short_mask} = '0;
      {h_ext_val, h_ext_drv, j_short_val, fails, compares} = '0;
      h_ext_drv = 8'hFF;
      lfsr_q = 8'h23;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      chk(hport_pull_on | jport_pin_oe | jport_pin_out | jport_drive_reduced, 8'h00);
      for (int a = 0; a < 16; a++) rchk(a[3:0], 8'h00);
      $display("test reset done");
      foreach (rw_ofs[i]) begin
         rnd(d);
         wr(rw_ofs[i], d);
         rchk(rw_ofs[i], d & rw_msk[i]);
      end
      wr(OFS_J_IN, 8'hFF);
      wr(4'hB, 8'hFF);
      rchk(4'hB, 8'h00);
      rchk(OFS_J_IE, d & 8'hC3);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         rnd(d);
         rnd(r);
         rnd(s);
         wr(OFS_H_PULL_EN, d);
         wr(OFS_H_POL, s);
         hport_dir <= r;
         settle;
         chk(hport_pull_on, d & ~r);
         chk(hport_pull_down, s);
      end
      $display("test pull done");
      // The first pass shorts two output pins against their data to mimic an overload.
      for (int i = 0; i < 6; i++) begin
         rnd(d);
         rnd(r);
         rnd(s);
         rnd(x);
         j_ext_val <= x;
         j_short_mask <= (i == 0) ? 8'h81 : 8'h00;
         j_short_val <= ~d;
         wr(OFS_J_DATA, d);
         wr(OFS_J_DIR, (i == 0) ? 8'hC3 : r);
         wr(OFS_J_RDR, s);
         if (i == 0) r = 8'hC3;
         settle;
         p = (i == 0) ? ((8'h81 & ~d) | (8'h42 & d)) & 8'hC3 : ((r & d) | (~r & x)) & 8'hC3;
         chk(jport_pin_out, d & 8'hC3);
         chk(jport_pin_oe, r & 8'hC3);
         chk(jport_drive_reduced, s & r & 8'hC3);
         rchk(OFS_J_DATA, ((r & d) | (~r & p)) & 8'hC3);
         rchk(OFS_J_IN, p);
      end
      $display("test port j done");
      j_short_mask <= 8'h00;
      wr(OFS_J_DIR, 8'h00);
      for (int n = 0; n < 8; n++) begin
         irq_case(n[0] ? OFS_J_POL : OFS_H_POL, n[0] ? J_IMPL_MASK : H_IMPL_MASK, n[1]);
      end
      wr(OFS_J_DIR, 8'hC3);
      wr(OFS_J_DATA, 8'hC3);
      wr(OFS_J_POL, 8'h00);
      settle;
      wr(OFS_J_IF, 8'hFF);
      wr(OFS_J_DATA, 8'h41);
      settle;
      rchk(OFS_J_IF, 8'h82);
      $display("test interrupts done");
      print_verdict();
   end
endmodule
`default_nettype wire
